// *** rcc_pkg.sv ***
// Purpose: Shared constants and types for the run clock configuration block
// Assumes: 32-bit AHB-Lite register bus, one system clock
// Notes: Only the middle fields of the configuration word are held here
package rcc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] RCC_RUN_CFG_OFF = 12'h060;
    localparam logic [11:0] RCC_ALT_CFG_OFF = 12'h070;

    // ----------------------------------------------------------------
    // Field positions of the run configuration word
    // ----------------------------------------------------------------
    localparam int RCC_SYSTEM_DIVISOR_LSB = 23;
    localparam int RCC_SYSTEM_DIVISOR_MSB = 26;
    localparam int RCC_SYSTEM_DIVISOR_EN_BIT = 22;
    localparam int RCC_PWM_EN_BIT = 20;
    localparam int RCC_PWM_SEL_LSB = 17;
    localparam int RCC_PWM_SEL_MSB = 19;
    localparam int RCC_PLL_OFF_BIT = 13;
    localparam int RCC_RSVD_ONE_BIT = 12;
    localparam int RCC_BYPASS_BIT = 11;

    // Alternate configuration word
    localparam int RCC_ALT_OVR_BIT = 31;
    localparam int RCC_ALT_DIV_LSB = 23;
    localparam int RCC_ALT_DIV_MSB = 28;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] RCC_SYSTEM_DIVISOR_RST = 4'hF;
    localparam logic RCC_SYSTEM_DIVISOR_EN_RST = 1'h0;
    localparam logic RCC_PWM_EN_RST = 1'h0;
    localparam logic [2:0] RCC_PWM_SEL_RST = 3'h7;
    localparam logic RCC_PLL_OFF_RST = 1'h1;
    localparam logic RCC_BYPASS_RST = 1'h1;
    localparam logic RCC_ALT_OVR_RST = 1'h0;
    localparam logic [5:0] RCC_ALT_DIV_RST = 6'h0F;

    // Highest predivider code with its own divisor; above it all divide by 64
    localparam logic [2:0] RCC_PWM_SEL_MAX = 3'h5;
    localparam int RCC_PWM_CNT_W = 6;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    localparam logic [1:0] RCC_HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [3:0] sys_div;
        logic sys_div_en;
        logic pwm_en;
        logic [2:0] pwm_sel;
        logic pll_off;
        logic bypass;
    } rcc_run_cfg_type;

    typedef struct packed {
        logic override_en;
        logic [5:0] alt_div;
    } rcc_alt_cfg_type;

    typedef struct packed {
        logic use_osc;
        logic div_active;
        logic [5:0] divisor;
    } rcc_sys_sel_type;

endpackage : rcc_pkg

// *** rcc_pwm_prediv.sv ***
// Purpose: Power-of-two predivider enable for the PWM timing reference
// Assumes: Runs on the system clock, one enable pulse per divided period
// Notes: Pulse lands on a system clock edge, so no phase offset arises
`timescale 1ns/1ps
`default_nettype none
module rcc_pwm_prediv #(
    parameter int CNT_W = rcc_pkg::RCC_PWM_CNT_W
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [2:0] pwm_sel,
    output logic pwm_tick
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mask;
    logic [2:0] shift;

    // Codes 5..7 all select the largest ratio
    assign shift = (pwm_sel > rcc_pkg::RCC_PWM_SEL_MAX) ? rcc_pkg::RCC_PWM_SEL_MAX : pwm_sel;
    assign mask = CNT_W'((2 << shift) - 1);
    assign pwm_tick = ((cnt_q & mask) == mask);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end
endmodule : rcc_pwm_prediv
`default_nettype wire

// *** rcc_ahb_slave.sv ***
// Purpose: AHB-Lite slave front end capturing the address phase
// Assumes: Single word transfers, zero wait states, OKAY response
// Notes: Write data is applied in the cycle after the address phase
`timescale 1ns/1ps
`default_nettype none
module rcc_ahb_slave (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    output logic wr_pend,
    output logic rd_pend,
    output logic [11:0] addr_q
);
    logic take;

    assign take = hsel && hready && htrans[1];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= '0;
        end else begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
            if (take) begin
                addr_q <= haddr[11:0];
            end
        end
    end
endmodule : rcc_ahb_slave
`default_nettype wire

// *** rcc_run_clock_cfg.sv ***
// Purpose: Run-mode clock configuration fields and derived clock selects
// Assumes: 20 MHz system clock, synchronous active-low reset, AHB-Lite bus
// Notes: Clock selections leave as registered controls for the clock tree
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Override bit selects alternate divisor field
// - PWM enable routes predivider to PWM clock
// - Predivider codes 0-4 power two; else 64
// - PWM ticks aligned to system clock edges
// - Power-off bit drives PLL directly, resets one
// - Bypass selects oscillator, else divided PLL
// - PLL selection always forces system divider
module rcc_run_clock_cfg (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic pll_power_off,
    output logic sys_use_osc,
    output logic sys_div_active,
    output logic [5:0] sys_divisor,
    output logic pwm_clk_en
);
    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    logic wr_pend;
    logic rd_pend;
    logic [11:0] addr_q;
    logic hit_run;
    logic hit_alt;

    rcc_ahb_slave u_slave (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .wr_pend(wr_pend),
        .rd_pend(),
        .addr_q(addr_q)
    );

    assign hit_run = (addr_q == rcc_pkg::RCC_RUN_CFG_OFF);
    assign hit_alt = (addr_q == rcc_pkg::RCC_ALT_CFG_OFF);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    rcc_pkg::rcc_run_cfg_type run_q;
    rcc_pkg::rcc_run_cfg_type run_d;
    rcc_pkg::rcc_alt_cfg_type alt_q;
    rcc_pkg::rcc_alt_cfg_type alt_d;

    // Reserved bits are simply never stored, so writes to them vanish
    assign run_d.sys_div = hwdata[rcc_pkg::RCC_SYSTEM_DIVISOR_MSB:rcc_pkg::RCC_SYSTEM_DIVISOR_LSB];
    assign run_d.sys_div_en = hwdata[rcc_pkg::RCC_SYSTEM_DIVISOR_EN_BIT];
    assign run_d.pwm_en = hwdata[rcc_pkg::RCC_PWM_EN_BIT];
    assign run_d.pwm_sel = hwdata[rcc_pkg::RCC_PWM_SEL_MSB:rcc_pkg::RCC_PWM_SEL_LSB];
    assign run_d.pll_off = hwdata[rcc_pkg::RCC_PLL_OFF_BIT];
    assign run_d.bypass = hwdata[rcc_pkg::RCC_BYPASS_BIT];
    assign alt_d.override_en = hwdata[rcc_pkg::RCC_ALT_OVR_BIT];
    assign alt_d.alt_div = hwdata[rcc_pkg::RCC_ALT_DIV_MSB:rcc_pkg::RCC_ALT_DIV_LSB];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            run_q.sys_div <= rcc_pkg::RCC_SYSTEM_DIVISOR_RST;
            run_q.sys_div_en <= rcc_pkg::RCC_SYSTEM_DIVISOR_EN_RST;
            run_q.pwm_en <= rcc_pkg::RCC_PWM_EN_RST;
            run_q.pwm_sel <= rcc_pkg::RCC_PWM_SEL_RST;
            run_q.pll_off <= rcc_pkg::RCC_PLL_OFF_RST;
            run_q.bypass <= rcc_pkg::RCC_BYPASS_RST;
        end else if (wr_pend && hit_run) begin
            run_q <= run_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            alt_q.override_en <= rcc_pkg::RCC_ALT_OVR_RST;
            alt_q.alt_div <= rcc_pkg::RCC_ALT_DIV_RST;
        end else if (wr_pend && hit_alt) begin
            alt_q <= alt_d;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [31:0] run_word;
    logic [31:0] alt_word;
    logic [31:0] rd_word;
    logic rd_take;

    always_comb begin
        run_word = '0;
        run_word[rcc_pkg::RCC_SYSTEM_DIVISOR_MSB:rcc_pkg::RCC_SYSTEM_DIVISOR_LSB] = run_q.sys_div;
        run_word[rcc_pkg::RCC_SYSTEM_DIVISOR_EN_BIT] = run_q.sys_div_en;
        run_word[rcc_pkg::RCC_PWM_EN_BIT] = run_q.pwm_en;
        run_word[rcc_pkg::RCC_PWM_SEL_MSB:rcc_pkg::RCC_PWM_SEL_LSB] = run_q.pwm_sel;
        run_word[rcc_pkg::RCC_PLL_OFF_BIT] = run_q.pll_off;
        run_word[rcc_pkg::RCC_RSVD_ONE_BIT] = 1'b1;
        run_word[rcc_pkg::RCC_BYPASS_BIT] = run_q.bypass;
        alt_word = '0;
        alt_word[rcc_pkg::RCC_ALT_OVR_BIT] = alt_q.override_en;
        alt_word[rcc_pkg::RCC_ALT_DIV_MSB:rcc_pkg::RCC_ALT_DIV_LSB] = alt_q.alt_div;
    end

    // Read data is registered at the address phase edge; unmapped reads give zero
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign rd_word = (haddr[11:0] == rcc_pkg::RCC_RUN_CFG_OFF) ? run_word :
                     (haddr[11:0] == rcc_pkg::RCC_ALT_CFG_OFF) ? alt_word : 32'h00000000;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            hrdata <= 32'h00000000;
        end else if (rd_take) begin
            hrdata <= rd_word;
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // System clock selection
    // ----------------------------------------------------------------
    rcc_pkg::rcc_sys_sel_type sel_d;
    rcc_pkg::rcc_sys_sel_type sel_q;

    assign sel_d.use_osc = run_q.bypass;
    // The PLL path cannot run undivided, so the divider is forced on
    assign sel_d.div_active = run_q.sys_div_en || !run_q.bypass;
    assign sel_d.divisor = alt_q.override_en ? alt_q.alt_div : {2'h0, run_q.sys_div};

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sel_q.use_osc <= rcc_pkg::RCC_BYPASS_RST;
            sel_q.div_active <= 1'b0;
            sel_q.divisor <= {2'h0, rcc_pkg::RCC_SYSTEM_DIVISOR_RST};
        end else begin
            sel_q <= sel_d;
        end
    end

    assign sys_use_osc = sel_q.use_osc;
    assign sys_div_active = sel_q.div_active;
    assign sys_divisor = sel_q.divisor;
    assign pll_power_off = run_q.pll_off;

    // ----------------------------------------------------------------
    // PWM clock
    // ----------------------------------------------------------------
    logic pwm_tick;
    logic pwm_en_d;

    rcc_pwm_prediv #(
        .CNT_W(rcc_pkg::RCC_PWM_CNT_W)
    ) u_prediv (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pwm_sel(run_q.pwm_sel),
        .pwm_tick(pwm_tick)
    );

    // Enable clear passes every system cycle through
    assign pwm_en_d = run_q.pwm_en ? pwm_tick : 1'b1;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pwm_clk_en <= 1'b1;
        end else begin
            pwm_clk_en <= pwm_en_d;
        end
    end

endmodule : rcc_run_clock_cfg
`default_nettype wire

// *** rcc_run_clock_cfg_properties.sv ***
// Purpose: Port-level properties of the run clock configuration block
// Assumes: Zero wait-state slave; shadow copies follow the bus writes
// Notes: Output checks wait one quiet cycle, as outputs other than pll_power_off lag by one edge
`timescale 1ns/1ps
`default_nettype none
module rcc_run_clock_cfg_chk (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic pll_power_off,
    input wire logic sys_use_osc,
    input wire logic sys_div_active,
    input wire logic [5:0] sys_divisor,
    input wire logic pwm_clk_en
);
    // ------------------------------------------------------------
    // Shadow copies of both configuration words
    // ------------------------------------------------------------
    logic run_wr_q;
    logic alt_wr_q;
    logic [31:0] run_q;
    logic [31:0] alt_q;
    wire take = hsel && hready && htrans[1] && hwrite;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            run_wr_q <= 1'b0;
            alt_wr_q <= 1'b0;
            run_q <= 32'h078E3800;
            alt_q <= 32'h07800000;
        end else begin
            run_wr_q <= take && haddr[11:0] == rcc_pkg::RCC_RUN_CFG_OFF;
            alt_wr_q <= take && haddr[11:0] == rcc_pkg::RCC_ALT_CFG_OFF;
            if (run_wr_q) run_q <= hwdata;
            if (alt_wr_q) alt_q <= hwdata;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_pll_off;
        $stable(run_q) |-> pll_power_off == run_q[13];
    endproperty
    property p_osc_sel;
        $stable(run_q) |-> sys_use_osc == run_q[11];
    endproperty
    property p_div_active;
        $stable(run_q) |-> sys_div_active == (!run_q[11] || run_q[22]);
    endproperty
    property p_pll_forces_div;
        !sys_use_osc |-> sys_div_active;
    endproperty
    property p_divisor;
        $stable(run_q) && $stable(alt_q)
            |-> sys_divisor == (alt_q[31] ? alt_q[28:23] : {2'h0, run_q[26:23]});
    endproperty
    property p_pwm_flat;
        $stable(run_q) && !run_q[20] |-> pwm_clk_en;
    endproperty
    property p_pwm_narrow;
        pwm_clk_en && run_q[20] && $stable(run_q) |=> !pwm_clk_en || $changed(run_q);
    endproperty
    property p_pwm_half;
        $fell(pwm_clk_en) && run_q[20] && run_q[19:17] == 3'h0 && $stable(run_q)
            |=> pwm_clk_en || $changed(run_q);
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("pll power-off wrong");
    a_osc_sel: assert property (p_osc_sel) else $error("source select wrong");
    a_div_active: assert property (p_div_active) else $error("divider use wrong");
    a_pll_forces_div: assert property (p_pll_forces_div) else $error("pll without divider");
    a_divisor: assert property (p_divisor) else $error("divisor wrong");
    a_pwm_flat: assert property (p_pwm_flat) else $error("pwm not undivided");
    a_pwm_narrow: assert property (p_pwm_narrow) else $error("pwm pulse too wide");
    a_pwm_half: assert property (p_pwm_half) else $error("pwm period not two");
    c_override: cover property (alt_q[31] && $stable(alt_q));
    c_pwm_div: cover property (pwm_clk_en && run_q[20]);
    c_pll_on: cover property (!sys_use_osc);
endmodule : rcc_run_clock_cfg_chk
`default_nettype wire

// *** rcc_run_clock_cfg_tb.sv ***
// Purpose: Self-checking bench for the run clock configuration block
// Assumes: Bench acts as the only bus master; hready loops back
// Notes: Random writes land on both words and on an unmapped word
`timescale 1ns/1ps
`default_nettype none
module rcc_run_clock_cfg_tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, pll_power_off, sys_use_osc, sys_div_active, pwm_clk_en;
    logic [31:0] hrdata;
    logic [5:0] sys_divisor;
    logic [31:0] run_m = 32'h078E3800;
    logic [31:0] alt_m = 32'h07800000;
    logic [31:0] rd;
    logic [11:0] adr [4] = '{12'h060, 12'h060, 12'h070, 12'h068};
    int fail_count = 0;
    int checks_done = 0;
    int seed = 59096;
    int i;
    int k;
    always #25 sys_clk = ~sys_clk;
    rcc_run_clock_cfg u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pll_power_off(pll_power_off),
        .sys_use_osc(sys_use_osc), .sys_div_active(sys_div_active),
        .sys_divisor(sys_divisor), .pwm_clk_en(pwm_clk_en));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= rcc_pkg::RCC_HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
        chk("hresp", 32'h0, hresp);
        chk("hreadyout", 32'h1, hreadyout);
        if (wr && a == 12'h060) run_m = d & 32'h07DE2800 | 32'h00001000;
        if (wr && a == 12'h070) alt_m = d & 32'h9F800000;
    endtask : xfer
    task automatic chk_out();
        repeat (2) @(posedge sys_clk);
        // Look mid-cycle so the outputs launched at the edge have settled
        @(negedge sys_clk);
        chk("pll_power_off", run_m[13], pll_power_off);
        chk("sys_use_osc", run_m[11], sys_use_osc);
        chk("sys_div_active", !run_m[11] || run_m[22], sys_div_active);
        chk("sys_divisor", alt_m[31] ? alt_m[28:23] : run_m[26:23], sys_divisor);
        if (!run_m[20]) chk("pwm_flat", 32'h1, pwm_clk_en);
    endtask : chk_out
    // Pulse counter is capped so a dead predivider cannot hang the run
    task automatic next_pulse();
        @(negedge sys_clk);
        k = 1;
        while (pwm_clk_en !== 1'b1 && k < 200) begin
            @(negedge sys_clk);
            k++;
        end
    endtask : next_pulse
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        xfer(1'b0, 12'h060, 32'h0);
        chk("run_reset", run_m, rd);
        xfer(1'b0, 12'h064, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk_out();
        for (i = 0; i < 16; i++) begin
            xfer(1'b1, adr[i % 4], $random(seed));
            xfer(1'b0, 12'h060, 32'h0);
            chk("run_read", run_m, rd);
            xfer(1'b0, 12'h070, 32'h0);
            chk("alt_read", alt_m, rd);
            chk_out();
        end
        for (i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            xfer(1'b1, 12'h060, 32'h00100000 | (i << 17));
            repeat (3) next_pulse();
            chk("pwm_period", 2 << (i > 5 ? 5 : i), k);
        end
        @(posedge sys_clk);
        xfer(1'b0, 12'h060, 32'h0);
        xfer(1'b1, 12'h060, rd ^ 32'h00002000);
        xfer(1'b0, 12'h060, 32'h0);
        chk("rmw_read", run_m, rd);
        xfer(1'b1, 12'h060, 32'h0);
        chk_out();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        wrap_up();
    end
endmodule : rcc_run_clock_cfg_tb
bind rcc_run_clock_cfg rcc_run_clock_cfg_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .pll_power_off(pll_power_off), .sys_use_osc(sys_use_osc),
    .sys_div_active(sys_div_active), .sys_divisor(sys_divisor), .pwm_clk_en(pwm_clk_en));
`default_nettype wire
